//--- hdl/acp_pkg.sv
// Constants shared by both ends of the converter serial link.
// Assumes a 20 MHz host clock and a link clock divided from it.
package acp_pkg;
  ////////////////////////////////////////////////////////////////////
  localparam int FRAME_BITS = 16;
  localparam int CTRL_W     = 12;
  localparam int ADDR_W     = 4;
  localparam int DATA_W     = 12;
  // Control word field positions
  localparam int CB_WRITE   = 11;
  localparam int CB_SEQ     = 10;
  localparam int CB_ADDR_HI = 9;
  localparam int CB_ADDR_LO = 6;
  localparam int CB_PM_HI   = 5;
  localparam int CB_PM_LO   = 4;
  localparam int CB_SHADOW  = 3;
  localparam int CB_WEAK    = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [15:0]       SHD_RST  = 16'h0000;
  // Power mode field codes
  localparam logic [1:0] PM_NORMAL   = 2'h3;
  localparam logic [1:0] PM_FULL_OFF = 2'h2;
  localparam logic [1:0] PM_AUTOSHUT = 2'h1;
  localparam logic [1:0] PM_AUTOSTBY = 2'h0;
  // Link clock falling edge numbers within a frame
  localparam logic [4:0] EDGE_CTRL_LAST = 5'h0C;
  localparam logic [4:0] EDGE_TRACK     = 5'h0E;
  localparam logic [4:0] EDGE_END       = 5'h10;
  ////////////////////////////////////////////////////////////////////
  // Host timing
  localparam int CLK_NS      = 50;
  localparam int SCLK_DIV    = 2;
  localparam int SCLK_NS     = CLK_NS * SCLK_DIV;
  localparam int WAKE_NS     = 1000;
  localparam int FRAME_NS    = FRAME_BITS * SCLK_NS;
  localparam logic [1:0] WAKE_FRAMES = 2'((WAKE_NS + FRAME_NS - 1) / FRAME_NS);
  localparam logic [1:0] INIT_FRAMES = 2'h2;
  localparam logic [4:0] RC_CAP_FIRST = 5'h02;
  localparam logic [4:0] RC_SDI_FIRST = 5'h02;
  localparam logic [4:0] RC_SDI_LAST  = 5'h10;
  localparam logic [4:0] RC_LAST      = 5'h11;
  ////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    PWR_NORMAL    = 2'b00,
    PWR_AUTO_SHUT = 2'b01,
    PWR_STANDBY   = 2'b10,
    PWR_FULL_OFF  = 2'b11
  } acp_pwr_type;
  typedef enum logic [0:0] {
    HST_IDLE  = 1'b0,
    HST_FRAME = 1'b1
  } acp_hst_type;
endpackage : acp_pkg

//--- hdl/acp_link_if.sv
// Serial link between the converter and its host.
// Assumes the host makes the link clock and the frame sync.
`timescale 1ns/100ps
`default_nettype none
interface acp_link_if;
  logic conv_serial_clock;
  logic conv_frame_sync_n;
  logic conv_serial_in;
  logic conv_serial_out;
  logic conv_serial_out_en;
  modport dev (
    input  conv_serial_clock,
    input  conv_frame_sync_n,
    input  conv_serial_in,
    output conv_serial_out,
    output conv_serial_out_en
  );
  modport host (
    output conv_serial_clock,
    output conv_frame_sync_n,
    output conv_serial_in,
    input  conv_serial_out,
    input  conv_serial_out_en
  );
endinterface : acp_link_if
`default_nettype wire

//--- hdl/acp_dev.sv
// Converter end: serial frame, control word and power mode sequencing.
// Assumes a free-running link clock; all logic runs on its falling edge.
// Functional notes
// (R1) Autoshutdown powers down after an updating conversion
// (R2) Powered down: hold state, keep control word
// (R3) Frame sync falling edge wakes, resumes tracking; code holds at frame start and tracks from edge 14
// (R4) Host waits 1 us after autoshutdown wake
// (R5) Host wake dummy frames keep write bit low
// (R6) Autostandby partial power down, bias stays on
// (R7) Host waits 1 us after autostandby wake
// (R8) Auto mode takes effect at conversion end
// (R9) Host: two all-ones frames, then configuration
// (R10) Control word valid after third frame end
// (R11) Host writes shadow no earlier than fourth frame
// (R12) Normal or full-off target skips second dummy
// (R13) Link clock is conversion and shift clock
// (R14) Frame start: hold, drive output, start conversion
// (R15) Track at edge 14; shadow frame at end
// (R16) Edge 16 releases output unless weak drive
// (R17) Four address bits precede twelve result bits
// (R18) Top address bit at start, shift on edges
// (R19) Last bit launched edge 15, sampled 16
// (R20) Field codes: 11 normal, 10 full off
// (R21) First 12 bits load control if write set
// (R22) Edge counter cleared at frame start
`timescale 1ns/100ps
`default_nettype none
module acp_dev
  import acp_pkg::*;
(
  acp_link_if.dev                  link,
  input  wire logic                rst_b,
  input  wire logic [DATA_W-1:0]   sample_data,
  output logic      [ADDR_W-1:0]   channel_sel,
  output acp_pwr_type              power_state,
  output logic                     track_mode,
  output logic      [CTRL_W-1:0]   ctrl_word,
  output logic      [15:0]         shadow_word
);

  ////////////////////////////////////////////////////////////////////
  // Reset synchroniser into the link domain
  logic                    rst_s1_r;
  logic                    rst_s2_r;
  logic                    in_frame_r;
  logic [4:0]              cnt_r;
  logic [15:0]             sin_r;
  logic [CTRL_W-1:0]       ctrl_r;
  logic [15:0]             shd_r;
  logic                    wrote_r;
  logic                    shd_arm_r;
  logic                    shd_frame_r;
  logic [FRAME_BITS-1:0]   out_r;
  logic                    sdo_r;
  logic                    sdo_en_r;
  logic                    track_r;
  logic [ADDR_W-1:0]       addr_r;
  acp_pwr_type             pwr_r;
  acp_pwr_type             pwr_end;
  logic                    frame_start;
  logic                    frame_end;
  logic                    in_edge;
  logic [4:0]              edge_k;
  logic [1:0]              pm;

  always_ff @(negedge link.conv_serial_clock) begin
    rst_s1_r <= rst_b;
    rst_s2_r <= rst_s1_r;
  end

  ////////////////////////////////////////////////////////////////////
  // Frame decode and edge counter
  assign frame_start = !link.conv_frame_sync_n && !in_frame_r;
  assign frame_end   = link.conv_frame_sync_n && in_frame_r;
  assign edge_k      = 5'(cnt_r + 5'h01);
  assign in_edge     = in_frame_r && !link.conv_frame_sync_n && (cnt_r < EDGE_END);
  assign pm          = ctrl_r[CB_PM_HI:CB_PM_LO];

  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      in_frame_r <= 1'b0;
      cnt_r      <= 5'h00;
    end else if (frame_start) begin
      in_frame_r <= 1'b1; // R14
      cnt_r      <= 5'h00; // R22
    end else if (frame_end) begin
      in_frame_r <= 1'b0;
    end else if (in_edge) begin
      cnt_r <= edge_k; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial input, control word and shadow word
  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      sin_r <= 16'h0000;
    end else if (frame_start) begin
      sin_r <= 16'h0000;
    end else if (in_edge) begin
      sin_r <= {sin_r[14:0], link.conv_serial_in}; // R13
    end
  end

  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      ctrl_r    <= CTRL_RST;
      wrote_r   <= 1'b0;
      shd_arm_r <= 1'b0;
    end else if (frame_start) begin
      wrote_r   <= 1'b0;
      shd_arm_r <= 1'b0;
    end else if (in_edge && edge_k == EDGE_CTRL_LAST && !shd_frame_r && sin_r[10]) begin
      ctrl_r    <= {sin_r[10:0], link.conv_serial_in}; // R21 R10 R2
      wrote_r   <= 1'b1;
      shd_arm_r <= !sin_r[9] && sin_r[2];
    end
  end

  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      shd_frame_r <= 1'b0;
      shd_r       <= SHD_RST;
    end else if (frame_start) begin
      shd_frame_r <= shd_arm_r;
    end else if (frame_end && shd_frame_r) begin
      shd_frame_r <= 1'b0;
      shd_r       <= sin_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial output: address then result, MSB first
  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      out_r    <= 16'h0000;
      sdo_r    <= 1'b0;
      sdo_en_r <= 1'b0;
    end else if (frame_start) begin
      out_r    <= {addr_r, sample_data}; // R17
      sdo_r    <= addr_r[ADDR_W-1]; // R18
      sdo_en_r <= 1'b1; // R14
    end else if (in_edge && edge_k < EDGE_END) begin
      sdo_r <= out_r[4'(15 - edge_k)]; // R18 R19
    end else if (in_edge) begin
      sdo_r    <= addr_r[ADDR_W-1];
      sdo_en_r <= ctrl_r[CB_WEAK]; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power state at conversion end
  always_comb begin
    pwr_end = PWR_NORMAL;
    case (pm)
      PM_NORMAL:   pwr_end = PWR_NORMAL; // R20
      PM_FULL_OFF: pwr_end = PWR_FULL_OFF; // R20
      PM_AUTOSHUT: pwr_end = wrote_r ? PWR_AUTO_SHUT : PWR_NORMAL; // R1
      PM_AUTOSTBY: pwr_end = wrote_r ? PWR_STANDBY : PWR_NORMAL; // R6
      default:     pwr_end = PWR_NORMAL;
    endcase
  end

  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      pwr_r <= PWR_NORMAL;
    end else if (frame_start && (pwr_r == PWR_AUTO_SHUT || pwr_r == PWR_STANDBY)) begin
      pwr_r <= PWR_NORMAL; // R3
    end else if (in_edge && edge_k == EDGE_END) begin
      pwr_r <= pwr_end; // R8
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Track and hold, channel mux
  always_ff @(negedge link.conv_serial_clock) begin
    if (!rst_s2_r) begin
      track_r <= 1'b1;
      addr_r  <= 4'h0;
    end else if (frame_start) begin
      track_r <= 1'b0; // R14
    end else if (frame_end && shd_frame_r) begin
      track_r <= 1'b1; // R15
    end else if (in_edge && edge_k == EDGE_TRACK) begin
      addr_r  <= ctrl_r[CB_ADDR_HI:CB_ADDR_LO];
      track_r <= !shd_frame_r && pwr_r != PWR_FULL_OFF; // R15
    end else if (in_edge && edge_k == EDGE_END && pwr_end != PWR_NORMAL) begin
      track_r <= 1'b0; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign link.conv_serial_out    = sdo_r;
  assign link.conv_serial_out_en = sdo_en_r;
  assign channel_sel             = addr_r;
  assign power_state             = pwr_r;
  assign track_mode              = track_r;
  assign ctrl_word               = ctrl_r;
  assign shadow_word             = shd_r;

endmodule : acp_dev
`default_nettype wire

//--- hdl/acp_host.sv
// Host end: link clock divider, frame engine and power-up sequencing.
// Assumes clock at 20 MHz; link clock is clock divided by two.
`timescale 1ns/100ps
`default_nettype none
module acp_host
  import acp_pkg::*;
(
  acp_link_if.host          link,
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         skip_second_dummy,
  input  wire logic         req,
  input  wire logic [15:0]  req_word,
  output logic              req_ready,
  output logic [15:0]       resp_word,
  output logic              resp_valid,
  output logic              init_done
);

  ////////////////////////////////////////////////////////////////////
  logic         sclk_r;
  logic         fs_r;
  logic         sdi_r;
  acp_hst_type  st_r;
  logic [4:0]   rc_r;
  logic [4:0]   rc_nxt;
  logic [15:0]  tx_r;
  logic [15:0]  rx_r;
  logic         sdo_s1_r;
  logic         sdo_s2_r;
  logic [1:0]   init_cnt_r;
  logic [1:0]   wake_left_r;
  logic         pend_r;
  logic [15:0]  pend_word_r;
  logic         auto_lp_r;
  logic         user_r;
  logic         ready_r;
  logic [15:0]  resp_r;
  logic         resp_valid_r;
  logic         init_done_r;
  logic         rise;
  logic         launch;
  logic         accept;

  assign rise   = !sclk_r;
  assign rc_nxt = 5'(rc_r + 5'h01);
  assign accept = req && ready_r;
  assign launch = rise && st_r == HST_IDLE && (init_cnt_r != INIT_FRAMES || pend_r);

  always_ff @(posedge clock) begin
    sdo_s1_r <= link.conv_serial_out;
    sdo_s2_r <= sdo_s1_r;
  end

  ////////////////////////////////////////////////////////////////////
  // Link clock divider
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sclk_r <= 1'b0;
    end else begin
      sclk_r <= !sclk_r; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame engine
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r         <= HST_IDLE;
      fs_r         <= 1'b1;
      sdi_r        <= 1'b0;
      rc_r         <= 5'h00;
      tx_r         <= 16'h0000;
      rx_r         <= 16'h0000;
      user_r       <= 1'b0;
      resp_r       <= 16'h0000;
      resp_valid_r <= 1'b0;
    end else begin
      resp_valid_r <= 1'b0;
      case (st_r)
        HST_IDLE: begin
          if (launch) begin
            st_r  <= HST_FRAME;
            fs_r  <= 1'b0;
            rc_r  <= 5'h00;
            if (init_cnt_r != INIT_FRAMES) begin
              tx_r   <= 16'hFFFF; // R9
              sdi_r  <= 1'b1;
              user_r <= 1'b0;
            end else if (wake_left_r != 2'h0) begin
              tx_r   <= 16'h0000; // R5
              sdi_r  <= 1'b0;
              user_r <= 1'b0;
            end else begin
              tx_r   <= pend_word_r;
              sdi_r  <= pend_word_r[15];
              user_r <= 1'b1;
            end
          end
        end
        HST_FRAME: begin
          if (rise) begin
            rc_r <= rc_nxt;
            if (rc_nxt >= RC_SDI_FIRST && rc_nxt <= RC_SDI_LAST) begin
              sdi_r <= tx_r[14];
              tx_r  <= {tx_r[14:0], 1'b0};
            end
            if (rc_nxt >= RC_CAP_FIRST) begin
              rx_r <= {rx_r[14:0], sdo_s2_r}; // R18 R19
            end
            if (rc_nxt == RC_LAST) begin
              fs_r         <= 1'b1;
              st_r         <= HST_IDLE;
              resp_r       <= {rx_r[14:0], sdo_s2_r};
              resp_valid_r <= user_r;
            end
          end
        end
        default: st_r <= HST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power-up sequence, wake dummies and request intake
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      init_cnt_r <= 2'h0;
      init_done_r <= 1'b0;
    end else begin
      if (launch && init_cnt_r != INIT_FRAMES) begin
        if (skip_second_dummy) begin
          init_cnt_r <= INIT_FRAMES; // R12
        end else begin
          init_cnt_r <= 2'(init_cnt_r + 2'h1); // R9
        end
      end
      init_done_r <= init_cnt_r == INIT_FRAMES && st_r == HST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pend_r      <= 1'b0;
      pend_word_r <= 16'h0000;
      wake_left_r <= 2'h0;
      auto_lp_r   <= 1'b0;
      ready_r     <= 1'b0;
    end else begin
      ready_r <= init_cnt_r == INIT_FRAMES && st_r == HST_IDLE && !pend_r && !accept
                 && !launch; // R11
      if (accept) begin
        pend_r      <= 1'b1;
        pend_word_r <= req_word;
        wake_left_r <= auto_lp_r ? WAKE_FRAMES : 2'h0; // R4 R7
      end else if (launch && init_cnt_r == INIT_FRAMES) begin
        if (wake_left_r != 2'h0) begin
          wake_left_r <= 2'(wake_left_r - 2'h1);
        end else begin
          pend_r <= 1'b0;
          if (pend_word_r[15]) begin
            auto_lp_r <= !pend_word_r[9];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign link.conv_serial_clock = sclk_r;
  assign link.conv_frame_sync_n = fs_r;
  assign link.conv_serial_in    = sdi_r;
  assign req_ready              = ready_r;
  assign resp_word              = resp_r;
  assign resp_valid             = resp_valid_r;
  assign init_done              = init_done_r;

endmodule : acp_host
`default_nettype wire

//--- dv/acp_link_checker.sv
// Assertions on the converter serial link, watched at its wires.
// Assumes the host makes the link clock; device logic runs on its falling edge.
`timescale 1ns/100ps
`default_nettype none
module acp_link_checker
  import acp_pkg::*;
(
  input wire logic conv_serial_clock,
  input wire logic conv_frame_sync_n,
  input wire logic conv_serial_in,
  input wire logic conv_serial_out,
  input wire logic conv_serial_out_en,
  input wire logic rst_b
);
  ////////////////////////////////////////////////////////////////////
  logic [1:0]  rs_r;
  logic        in_r;
  logic [4:0]  cnt_r;
  logic [1:0]  fnum_r;
  logic [10:0] sr_r;
  logic        weak_r;
  logic        a3_r;
  logic        need_r;
  logic        start;
  logic        last;
  logic [11:0] cw;
  assign start = !conv_frame_sync_n && !in_r;
  assign last  = in_r && !conv_frame_sync_n && cnt_r == 5'h0F;
  assign cw    = {sr_r, conv_serial_in};
  // Reset as the device sees it
  always_ff @(negedge conv_serial_clock or negedge rst_b) begin
    if (!rst_b) rs_r <= 2'h0;
    else rs_r <= {rs_r[0], 1'b1};
  end
  // Frame and edge count
  always_ff @(negedge conv_serial_clock) begin
    if (!rs_r[1]) begin
      in_r   <= 1'b0;
      cnt_r  <= 5'h00;
      fnum_r <= 2'h0;
    end else if (conv_frame_sync_n) begin
      in_r <= 1'b0;
    end else if (!in_r) begin
      in_r   <= 1'b1;
      cnt_r  <= 5'h00;
      fnum_r <= (fnum_r == 2'h3) ? fnum_r : fnum_r + 2'h1;
    end else if (cnt_r != 5'h10) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // Copy of the written control fields
  always_ff @(negedge conv_serial_clock) begin
    if (!rs_r[1]) begin
      sr_r   <= 11'h000;
      weak_r <= 1'b0;
      a3_r   <= 1'b0;
      need_r <= 1'b0;
    end else if (in_r && !conv_frame_sync_n) begin
      sr_r <= cw[10:0];
      if (cnt_r == 5'h00) need_r <= 1'b0;
      if (cnt_r == 5'h0B && cw[CB_WRITE]) begin
        weak_r <= cw[CB_WEAK];
        a3_r   <= cw[CB_ADDR_HI];
        need_r <= !cw[CB_PM_HI];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  default clocking dc @(negedge conv_serial_clock); endclocking
  default disable iff (!rs_r[1]);
  start_drive_a: assert property (start |=> conv_serial_out_en)
    else $error("output not driven after frame start");
  frame_drive_a: assert property (
    in_r && !conv_frame_sync_n && cnt_r < 5'h10 |-> conv_serial_out_en)
    else $error("output released inside frame");
  top_bit_a: assert property (start |=> conv_serial_out == a3_r)
    else $error("wrong first address bit");
  end_release_a: assert property (last |=> conv_serial_out_en == weak_r)
    else $error("wrong drive after last edge");
  next_top_a: assert property (last |-> ##1 (!weak_r || conv_serial_out == a3_r))
    else $error("weak drive not next address bit");
  frame_len_a: assert property (last |=> conv_frame_sync_n)
    else $error("frame not sixteen edges long");
  init_ones_a: assert property (
    in_r && !conv_frame_sync_n && fnum_r == 2'h1 && cnt_r < 5'h10 |-> conv_serial_in)
    else $error("first dummy frame not all ones");
  wake_dummy_a: assert property (start && need_r |=> !conv_serial_in)
    else $error("wake frame writes control");
endmodule : acp_link_checker
`default_nettype wire

//--- dv/tb.sv
// Bench for both ends of the converter serial link.
// Assumes the host divides its own clock to make the link clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb
  import acp_pkg::*;
();
  logic        clock;
  logic        rst_b;
  logic        dev_rst_b;
  logic        skip;
  logic        req;
  logic        req_ready;
  logic        resp_valid;
  logic        init_done;
  logic        track_mode;
  logic        auto_p;
  logic [15:0] req_word;
  logic [15:0] resp_word;
  logic [15:0] wsr;
  logic [15:0] shadow_word;
  logic [11:0] sample_data;
  logic [11:0] ctrl_word;
  logic [11:0] ctrl_e;
  logic [3:0]  channel_sel;
  logic [3:0]  chan;
  acp_pwr_type power_state;
  int          wc;
  int          nfr;
  int          checks;
  int          fail_count;
  acp_link_if link ();
  acp_host i_acp_host (.link(link.host), .clock(clock), .rst_b(rst_b),
    .skip_second_dummy(skip), .req(req), .req_word(req_word), .req_ready(req_ready),
    .resp_word(resp_word), .resp_valid(resp_valid), .init_done(init_done));
  acp_dev i_acp_dev (.link(link.dev), .rst_b(dev_rst_b), .sample_data(sample_data),
    .channel_sel(channel_sel), .power_state(power_state), .track_mode(track_mode),
    .ctrl_word(ctrl_word), .shadow_word(shadow_word));
  acp_link_checker i_acp_link_checker (.conv_serial_clock(link.conv_serial_clock),
    .conv_frame_sync_n(link.conv_frame_sync_n), .conv_serial_in(link.conv_serial_in),
    .conv_serial_out(link.conv_serial_out), .conv_serial_out_en(link.conv_serial_out_en),
    .rst_b(dev_rst_b));
  ////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Wire monitor: bits sampled on link falling edges 1 to 16
  always @(negedge link.conv_serial_clock) begin
    if (link.conv_frame_sync_n) wc = 0;
    else if (wc < 17) begin
      if (wc > 0) wsr = {wsr[14:0], link.conv_serial_out};
      wc++;
    end
  end
  always @(negedge link.conv_frame_sync_n) nfr++;
  ////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] mk(input logic wr, input logic [3:0] a,
                                     input logic [1:0] pm, input logic wk);
    return {wr, 1'b0, a, pm, 1'b0, wk, 6'h00};
  endfunction : mk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic xfer(input logic [15:0] w, input logic [11:0] d, input acp_pwr_type ps);
    logic [15:0] ex;
    int          n0;
    int          t;
    ex = {chan, d};
    n0 = nfr;
    t = 0;
    do @(negedge clock); while (req_ready !== 1'b1 && ++t < 2000);
    @(posedge clock);
    req <= 1'b1;
    req_word <= w;
    sample_data <= d;
    @(posedge clock);
    req <= 1'b0;
    do @(negedge clock); while (resp_valid !== 1'b1 && ++t < 4000);
    if (w[15]) ctrl_e = w[15:4];
    `CHK("frames", auto_p ? 2 : 1, nfr - n0)
    if (w[15]) auto_p = !w[9];
    chan = ctrl_e[CB_ADDR_HI:CB_ADDR_LO];
    `CHK("timeout", 1'b0, t >= 4000)
    `CHK("resp", ex, resp_word)
    `CHK("wire", ex, wsr)
    `CHK("ctrl", ctrl_e, ctrl_word)
    `CHK("power", ps, power_state)
    `CHK("out_en", ctrl_e[CB_WEAK], link.conv_serial_out_en)
    `CHK("chan", chan, channel_sel)
  endtask : xfer
  task automatic probe(input acp_pwr_type ps);
    @(negedge link.conv_frame_sync_n);
    repeat (13) @(negedge link.conv_serial_clock);
    #1;
    `CHK("hold", 1'b0, track_mode)
    `CHK("mid power", ps, power_state)
    repeat (2) @(negedge link.conv_serial_clock);
    #1;
    `CHK("track", 1'b1, track_mode)
  endtask : probe
  ////////////////////////////////////////////////////////////////////
  task automatic t_init(input logic s);
    int t;
    @(posedge clock);
    rst_b <= 1'b0;
    dev_rst_b <= 1'b0;
    skip <= s;
    repeat (4) @(posedge clock);
    nfr = 0;
    rst_b <= 1'b1;
    repeat (9) @(posedge clock);
    dev_rst_b <= 1'b1;
    t = 0;
    do @(negedge clock); while (init_done !== 1'b1 && ++t < 2000);
    `CHK("init frames", s ? 1 : 2, nfr)
    if (!s) `CHK("init ctrl", 12'hFFF, ctrl_word)
    ctrl_e = s ? CTRL_RST : 12'hFFF;
    chan = ctrl_e[CB_ADDR_HI:CB_ADDR_LO];
    auto_p = 1'b0;
    $display("test init done");
  endtask : t_init
  task automatic t_modes;
    fork
      xfer(mk(1'b1, 4'h5, PM_NORMAL, 1'b0), 12'hA5C, PWR_NORMAL);
      probe(PWR_NORMAL);
    join
    xfer(mk(1'b0, 4'h9, PM_FULL_OFF, 1'b1), 12'h3C3, PWR_NORMAL);
    xfer(mk(1'b1, 4'h5, PM_FULL_OFF, 1'b1), 12'h0F0, PWR_FULL_OFF);
    xfer(mk(1'b1, 4'h5, PM_NORMAL, 1'b1), 12'hF0F, PWR_NORMAL);
    $display("test modes done");
  endtask : t_modes
  task automatic t_shadow;
    xfer(mk(1'b1, 4'h1, PM_NORMAL, 1'b0) | 16'h0080, 12'h0C3, PWR_NORMAL);
    fork
      xfer(16'h6B5D, 12'h3E1, PWR_NORMAL);
      begin
        @(negedge link.conv_frame_sync_n);
        repeat (15) @(negedge link.conv_serial_clock);
        #1;
        `CHK("shd hold", 1'b0, track_mode)
      end
    join
    repeat (2) @(negedge clock);
    `CHK("shd word", 16'h6B5D, shadow_word)
    `CHK("shd track", 1'b1, track_mode)
    $display("test shadow done");
  endtask : t_shadow
  task automatic t_autoshut;
    fork
      xfer(mk(1'b1, 4'h2, PM_AUTOSHUT, 1'b0), 12'h123, PWR_AUTO_SHUT);
      probe(PWR_NORMAL);
    join
    repeat (40) @(negedge clock);
    `CHK("shut power", PWR_AUTO_SHUT, power_state)
    `CHK("shut hold", 1'b0, track_mode)
    `CHK("shut ctrl", ctrl_e, ctrl_word)
    fork
      xfer(mk(1'b1, 4'h6, PM_NORMAL, 1'b0), 12'h456, PWR_NORMAL);
      probe(PWR_NORMAL);
    join
    $display("test autoshutdown done");
  endtask : t_autoshut
  task automatic t_standby;
    xfer(mk(1'b1, 4'hA, PM_AUTOSTBY, 1'b1), 12'h789, PWR_STANDBY);
    `CHK("stby hold", 1'b0, track_mode)
    xfer(mk(1'b1, 4'h3, PM_NORMAL, 1'b0), 12'hABC, PWR_NORMAL);
    $display("test autostandby done");
  endtask : t_standby
  ////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    dev_rst_b = 1'b0;
    skip = 1'b0;
    req = 1'b0;
    req_word = 16'h0000;
    sample_data = 12'h000;
    checks = 0;
    fail_count = 0;
    t_init(1'b0);
    t_modes();
    t_shadow();
    t_autoshut();
    t_standby();
    t_init(1'b1);
    xfer(mk(1'b1, 4'h7, PM_NORMAL, 1'b0), 12'h5A5, PWR_NORMAL);
    $display("test skip dummy done");
    wrap_up();
  end
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
